// ==== logic/wdtr_pkg.sv ====
// Package of constants and types for the watchdog timer register block.
// Functional notes
// - Timeout field bits 5:2 selects 8 to 8K oscillator cycles, doubling per code.
// - Reserved timeout codes 1011 to 1111 never cause a timeout.
// - In window mode the timeout field gives the open window length.
// - Timeout field and enable load from fuses; change-enable starts at zero.
// - Control fields change only when the same write sets bit 0.
// - Control bit 1 set runs the watchdog; cleared stops it.
// - Both configuration registers change only under change protection.
// - Lock fuse makes control and closed field read-only; window bits 1:0 stay writable.
// - Window bits 5:2 give closed window length, coded as the timeout field.
// - Reserved closed codes 1011 to 1111 never give a closed-window timeout.
// - In normal mode the closed-window field has no effect.
// - Closed field and window enable load from fuses; window change-enable resets zero.
// - Window fields change only when the same write sets its change-enable bit.
// - Window enable set selects window mode; cleared returns to normal mode.
// - Busy flag in status bit 0 is set while a written value crosses over.
// - Crossing and busy flag happen only while the watchdog is enabled or a control write starts it.
// - Reserved bits read zero; software writes zeros to them.
// - No restart before the timeout expires issues a system reset.
// - A restart during the closed window issues an immediate system reset.
// - The open window follows the closed one; total is their sum.
// - With lock set software cannot stop it; reset resumes fuse operation.
`default_nettype none
package wdtr_pkg;

   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_WIN    = 8'h01;
   localparam logic [7:0] OFF_STATUS = 8'h02;

   localparam int CHG_EN_BIT   = 0;
   localparam int ENABLE_BIT   = 1;
   localparam int SEL_LSB      = 2;
   localparam int SEL_MSB      = 5;
   localparam int BUSY_BIT     = 0;

   localparam logic [3:0] MAX_CODE   = 4'ha;
   localparam logic [3:0] SEL_RESET  = 4'h0;
   localparam int         BASE_TICKS = 8;
   // Oscillator ticks that a written value takes to reach the counter side.
   localparam logic [1:0] SYNC_TICKS = 2'h2;

   typedef struct packed {
      logic [3:0] timeoutSel;
      logic       enable;
      logic [3:0] windowSel;
      logic       windowEn;
   } wdtr_cfg_t;

   localparam wdtr_cfg_t CFG_RESET = '{
      timeoutSel: SEL_RESET, enable: 1'b0,
      windowSel: SEL_RESET, windowEn: 1'b0};

   typedef enum logic {
      PH_CLOSED,
      PH_OPEN
   } wdtr_phase_t;

endpackage
`default_nettype wire

// ==== logic/wdtr_core.sv ====
// Watchdog timer with its configuration, window and status registers.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module wdtr_core #(
   parameter int ADDR_W = 8,
   parameter int CNT_W  = 14
) (
   input  wire  logic              core_clk,
   input  wire  logic              nrst,
   input  wire  logic [ADDR_W-1:0] regAddr,
   input  wire  logic [7:0]        regWrData,
   input  wire  logic              regWr,
   input  wire  logic              regRd,
   output var   logic [7:0]        regRdData,
   input  wire  logic              cfgUnlock,
   input  wire  logic              lockFuse,
   input  wire  logic [3:0]        timeoutFuseField,
   input  wire  logic              enableFuse,
   input  wire  logic [3:0]        windowFuseField,
   input  wire  logic              windowEnFuse,
   input  wire  logic              lowPowerOscTick,
   input  wire  logic              restartInstr,
   output var   logic              domainCrossingPending,
   output var   logic              sysReset
);

   wdtr_pkg::wdtr_cfg_t   cfg_q;
   wdtr_pkg::wdtr_cfg_t   active_q;
   wdtr_pkg::wdtr_phase_t phase_q;
   logic                  loaded_q;
   logic                  busy_q;
   logic [1:0]            syncCnt_q;
   logic                  restartPend_q;
   logic [CNT_W-1:0]      cnt_q;
   logic [7:0]            rdData_q;
   logic                  sysReset_q;

   logic                  ctrlWr;
   logic                  winWr;
   logic                  syncNeeded;
   logic                  syncDone;
   logic                  inClosed;
   logic [CNT_W-1:0]      cntInc;
   logic                  closedEnd;
   logic                  openEnd;
   logic                  closedRestart;
   logic                  restartOk;

   function automatic logic codeValid(input logic [3:0] sel);
      codeValid = (sel <= wdtr_pkg::MAX_CODE);
   endfunction

   function automatic logic [CNT_W-1:0] periodOf(input logic [3:0] sel);
      logic [CNT_W-1:0] base;
      base     = CNT_W'(wdtr_pkg::BASE_TICKS);
      periodOf = base << sel;
   endfunction

   // Writes pass only under the protection window and with their own
   // change-enable bit set in the same write.
   assign ctrlWr = regWr && (regAddr == ADDR_W'(wdtr_pkg::OFF_CTRL))
                   && cfgUnlock && !lockFuse
                   && regWrData[wdtr_pkg::CHG_EN_BIT];
   assign winWr  = regWr && (regAddr == ADDR_W'(wdtr_pkg::OFF_WIN))
                   && cfgUnlock
                   && regWrData[wdtr_pkg::CHG_EN_BIT];

   // A write only needs a crossing while the watchdog runs or is started.
   assign syncNeeded = (ctrlWr || winWr) && (cfg_q.enable
                       || (ctrlWr && regWrData[wdtr_pkg::ENABLE_BIT]));
   assign syncDone   = busy_q && lowPowerOscTick
                       && (syncCnt_q == wdtr_pkg::SYNC_TICKS - 2'h1);

   // Fuses are taken one edge after reset release, then software owns it.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         loaded_q <= 1'b0;
         cfg_q    <= wdtr_pkg::CFG_RESET;
      end else if (!loaded_q) begin
         loaded_q         <= 1'b1;
         cfg_q.timeoutSel <= timeoutFuseField;
         cfg_q.enable     <= enableFuse;
         cfg_q.windowSel  <= windowFuseField;
         cfg_q.windowEn   <= windowEnFuse;
      end else begin
         if (ctrlWr) begin
            cfg_q.timeoutSel <= regWrData[wdtr_pkg::SEL_MSB:wdtr_pkg::SEL_LSB];
            cfg_q.enable     <= regWrData[wdtr_pkg::ENABLE_BIT];
         end
         if (winWr) begin
            if (!lockFuse) begin
               cfg_q.windowSel <=
                  regWrData[wdtr_pkg::SEL_MSB:wdtr_pkg::SEL_LSB];
            end
            cfg_q.windowEn <= regWrData[wdtr_pkg::ENABLE_BIT];
         end
      end
   end

   // A new write during a crossing restarts it, so the set beats the clear.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         busy_q    <= 1'b0;
         syncCnt_q <= 2'h0;
      end else if (syncNeeded) begin
         busy_q    <= 1'b1;
         syncCnt_q <= 2'h0;
      end else if (syncDone) begin
         busy_q    <= 1'b0;
         syncCnt_q <= 2'h0;
      end else if (busy_q && lowPowerOscTick) begin
         syncCnt_q <= syncCnt_q + 2'h1;
      end
   end

   // Counter side sees settings only once they have crossed; a stopped
   // watchdog has nothing to protect, so it follows immediately.
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         active_q <= wdtr_pkg::CFG_RESET;
      end else if (!loaded_q) begin
         // A fuse-enabled watchdog must run straight from reset, before
         // any crossing has ever happened.
         active_q.timeoutSel <= timeoutFuseField;
         active_q.enable     <= enableFuse;
         active_q.windowSel  <= windowFuseField;
         active_q.windowEn   <= windowEnFuse;
      end else if (syncDone || (!busy_q && !cfg_q.enable)) begin
         active_q <= cfg_q;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         restartPend_q <= 1'b0;
      end else if (restartInstr) begin
         restartPend_q <= 1'b1;
      end else if (lowPowerOscTick) begin
         restartPend_q <= 1'b0;
      end
   end

   assign inClosed = (phase_q == wdtr_pkg::PH_CLOSED) && active_q.windowEn
                     && codeValid(active_q.windowSel);
   assign cntInc   = cnt_q + CNT_W'(1);
   assign closedEnd = inClosed
                      && (cntInc == periodOf(active_q.windowSel));
   assign openEnd  = !inClosed && codeValid(active_q.timeoutSel)
                     && (cntInc == periodOf(active_q.timeoutSel));
   assign closedRestart = active_q.enable && lowPowerOscTick
                          && restartPend_q && inClosed;
   assign restartOk     = active_q.enable && lowPowerOscTick
                          && restartPend_q && !inClosed;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_q      <= '0;
         phase_q    <= wdtr_pkg::PH_CLOSED;
         sysReset_q <= 1'b0;
      end else begin
         sysReset_q <= 1'b0;
         if (!active_q.enable) begin
            cnt_q   <= '0;
            phase_q <= wdtr_pkg::PH_CLOSED;
         end else if (lowPowerOscTick) begin
            if (closedRestart) begin
               sysReset_q <= 1'b1;
               cnt_q      <= '0;
               phase_q    <= wdtr_pkg::PH_CLOSED;
            end else if (restartPend_q) begin
               cnt_q   <= '0;
               phase_q <= wdtr_pkg::PH_CLOSED;
            end else if (closedEnd) begin
               cnt_q   <= '0;
               phase_q <= wdtr_pkg::PH_OPEN;
            end else if (openEnd) begin
               sysReset_q <= 1'b1;
               cnt_q      <= '0;
               phase_q    <= wdtr_pkg::PH_CLOSED;
            end else if (!codeValid(active_q.timeoutSel) && !inClosed) begin
               cnt_q <= cnt_q;
            end else begin
               cnt_q <= cntInc;
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rdData_q <= 8'h00;
      end else if (regRd) begin
         case (regAddr)
            ADDR_W'(wdtr_pkg::OFF_CTRL):
               rdData_q <= {2'h0, cfg_q.timeoutSel, cfg_q.enable, 1'b0};
            ADDR_W'(wdtr_pkg::OFF_WIN):
               rdData_q <= {2'h0, cfg_q.windowSel, cfg_q.windowEn, 1'b0};
            ADDR_W'(wdtr_pkg::OFF_STATUS):
               rdData_q <= {7'h00, busy_q};
            default:
               rdData_q <= 8'h00;
         endcase
      end else begin
         rdData_q <= 8'h00;
      end
   end

   assign regRdData             = rdData_q;
   assign domainCrossingPending = busy_q;
   assign sysReset              = sysReset_q;

   a_reserved_timeout: assert property (@(posedge core_clk) disable iff (!nrst)
      !codeValid(active_q.timeoutSel) && !restartPend_q |=> !sysReset_q)
      else $error("reset issued with reserved timeout code");

   a_ctrl_gated: assert property (@(posedge core_clk) disable iff (!nrst)
      loaded_q && regWr && regAddr == ADDR_W'(wdtr_pkg::OFF_CTRL)
      && (!regWrData[wdtr_pkg::CHG_EN_BIT] || !cfgUnlock)
      |=> $stable(cfg_q.timeoutSel) && $stable(cfg_q.enable))
      else $error("control changed without change enable");

   a_lock_readonly: assert property (@(posedge core_clk) disable iff (!nrst)
      loaded_q && lockFuse |=> $stable(cfg_q.timeoutSel)
      && $stable(cfg_q.enable) && $stable(cfg_q.windowSel))
      else $error("locked field changed");

   a_win_enable: assert property (@(posedge core_clk) disable iff (!nrst)
      loaded_q && winWr |=> cfg_q.windowEn == $past(regWrData[1]))
      else $error("window enable not written");

   a_busy_set: assert property (@(posedge core_clk) disable iff (!nrst)
      loaded_q && ctrlWr && regWrData[wdtr_pkg::ENABLE_BIT]
      |=> busy_q ##1 (busy_q || active_q == $past(cfg_q)))
      else $error("busy not raised on write");

   a_busy_idle: assert property (@(posedge core_clk) disable iff (!nrst)
      loaded_q && !cfg_q.enable && !busy_q && !ctrlWr |=> !busy_q)
      else $error("busy raised while disabled");

   a_status_read: assert property (@(posedge core_clk) disable iff (!nrst)
      regRd && regAddr == ADDR_W'(wdtr_pkg::OFF_STATUS)
      |=> regRdData == {7'h00, $past(busy_q)})
      else $error("status read wrong");

   a_timeout_reset: assert property (@(posedge core_clk) disable iff (!nrst)
      active_q.enable && lowPowerOscTick && !restartPend_q && openEnd
      |=> sysReset_q ##1 !sysReset_q)
      else $error("missed timeout reset");

   a_closed_restart: assert property (@(posedge core_clk) disable iff (!nrst)
      closedRestart |=> sysReset_q && cnt_q == '0)
      else $error("closed window restart not reset");

   a_restart_clear: assert property (@(posedge core_clk) disable iff (!nrst)
      restartOk |=> cnt_q == '0 && !sysReset_q
      && phase_q == wdtr_pkg::PH_CLOSED)
      else $error("restart did not clear counter");

   // The checks below guard paths that the bench reaches only rarely, such
   // as the fuse load and the end of the closed phase.
   a_fuse_load: assert property (@(posedge core_clk) disable iff (!nrst)
      !loaded_q |=> loaded_q
      && cfg_q.timeoutSel == $past(timeoutFuseField)
      && cfg_q.enable == $past(enableFuse)
      && active_q.enable == $past(enableFuse))
      else $error("control fuses not loaded");

   a_fuse_window: assert property (@(posedge core_clk) disable iff (!nrst)
      !loaded_q |=> cfg_q.windowSel == $past(windowFuseField)
      && cfg_q.windowEn == $past(windowEnFuse))
      else $error("window fuses not loaded");

   a_ctrl_write: assert property (@(posedge core_clk) disable iff (!nrst)
      loaded_q && ctrlWr
      |=> cfg_q.timeoutSel
          == $past(regWrData[wdtr_pkg::SEL_MSB:wdtr_pkg::SEL_LSB])
      && cfg_q.enable == $past(regWrData[wdtr_pkg::ENABLE_BIT]))
      else $error("accepted control write not stored");

   a_win_write: assert property (@(posedge core_clk) disable iff (!nrst)
      loaded_q && winWr && !lockFuse
      |=> cfg_q.windowSel
          == $past(regWrData[wdtr_pkg::SEL_MSB:wdtr_pkg::SEL_LSB]))
      else $error("accepted window write not stored");

   a_win_gated: assert property (@(posedge core_clk) disable iff (!nrst)
      loaded_q && regWr && regAddr == ADDR_W'(wdtr_pkg::OFF_WIN)
      && (!regWrData[wdtr_pkg::CHG_EN_BIT] || !cfgUnlock)
      |=> $stable(cfg_q.windowSel) && $stable(cfg_q.windowEn))
      else $error("window changed without change enable");

   a_lock_stop: assert property (@(posedge core_clk) disable iff (!nrst)
      loaded_q && lockFuse && cfg_q.enable |=> cfg_q.enable)
      else $error("locked watchdog was stopped");

   a_disabled_idle: assert property (@(posedge core_clk) disable iff (!nrst)
      !active_q.enable |=> cnt_q == '0 && !sysReset_q)
      else $error("stopped watchdog still counting");

   // A pending clear must never be lost behind a later oscillator tick.
   a_restart_latch: assert property (@(posedge core_clk) disable iff (!nrst)
      restartInstr |=> restartPend_q)
      else $error("restart request not latched");

   a_closed_end: assert property (@(posedge core_clk) disable iff (!nrst)
      active_q.enable && lowPowerOscTick && !restartPend_q && closedEnd
      |=> phase_q == wdtr_pkg::PH_OPEN && cnt_q == '0 && !sysReset_q)
      else $error("open window did not follow closed");

   a_reserved_closed: assert property (@(posedge core_clk) disable iff (!nrst)
      active_q.enable && lowPowerOscTick && restartPend_q
      && active_q.windowEn && !codeValid(active_q.windowSel)
      |=> !sysReset_q)
      else $error("reserved closed code gave a reset");

   a_normal_ignores: assert property (@(posedge core_clk) disable iff (!nrst)
      active_q.enable && lowPowerOscTick && restartPend_q
      && !active_q.windowEn |=> !sysReset_q && cnt_q == '0)
      else $error("normal mode restart gave a reset");

   a_busy_clear: assert property (@(posedge core_clk) disable iff (!nrst)
      syncDone && !syncNeeded
      |=> !busy_q && active_q == $past(cfg_q))
      else $error("crossing end did not hand over");

   a_reserved_read: assert property (@(posedge core_clk) disable iff (!nrst)
      regRd && regAddr != ADDR_W'(wdtr_pkg::OFF_STATUS)
      |=> regRdData[7:6] == 2'h0 && !regRdData[0])
      else $error("reserved bits read non-zero");

endmodule
`default_nettype wire

// ==== bench/wdtr_bench.sv ====
// Self-checking testbench for the watchdog timer register block.
`timescale 1ns/100ps
`default_nettype none
module wdtr_bench;
   logic       core_clk = 1'b0;
   logic       nrst = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic       regWr = 1'b0;
   logic       regRd = 1'b0;
   logic [7:0] regRdData;
   logic       cfgUnlock = 1'b1;
   logic       lockFuse = 1'b0;
   logic [3:0] tFuse = 4'h0;
   logic [3:0] wFuse = 4'h0;
   logic       enFuse = 1'b0;
   logic       wenFuse = 1'b0;
   logic       lowPowerOscTick = 1'b0;
   logic       restartInstr = 1'b0;
   logic       domainCrossingPending;
   logic       sysReset;
   logic [7:0] expQ[$];
   logic       rdWas = 1'b0;
   logic [7:0] resetSeen = 8'h00;
   logic [7:0] rv;
   int         failCount = 0;
   int         nChecks = 0;

   always #2.5 core_clk = ~core_clk;

   wdtr_core i_wdtr_core (
      .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .cfgUnlock(cfgUnlock), .lockFuse(lockFuse),
      .timeoutFuseField(tFuse), .enableFuse(enFuse),
      .windowFuseField(wFuse), .windowEnFuse(wenFuse),
      .lowPowerOscTick(lowPowerOscTick), .restartInstr(restartInstr),
      .domainCrossingPending(domainCrossingPending), .sysReset(sysReset));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      nChecks++;
      if (seen !== exp) begin
         failCount++;
         $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // Read data stand only in the cycle after the strobe, so they are taken
   // at the falling edge of that cycle, clear of the launching edge.
   always @(negedge core_clk) begin
      if (rdWas)
         check(regRdData, expQ.pop_front());
      rdWas = regRd;
      if (sysReset === 1'b1)
         resetSeen = resetSeen + 8'h01;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      expQ.push_back(exp);
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
   endtask

   task automatic tick(input int n);
      repeat (n) begin
         @(posedge core_clk);
         lowPowerOscTick <= 1'b1;
         @(posedge core_clk);
         lowPowerOscTick <= 1'b0;
         repeat (2) @(posedge core_clk);
      end
   endtask

   task automatic restart();
      @(posedge core_clk);
      restartInstr <= 1'b1;
      @(posedge core_clk);
      restartInstr <= 1'b0;
   endtask

   task automatic expectResets(input int n, input logic [7:0] k);
      logic [7:0] r0;
      r0 = resetSeen;
      tick(n);
      check(resetSeen - r0, k);
   endtask

   // A restart is consumed at the first tick, then the period runs out.
   task automatic timeoutSeq(input int quiet, input int more);
      restart();
      expectResets(quiet, 8'h00);
      expectResets(more, 8'h01);
   endtask

   task automatic complete_run();
      $display("Checks: %0d, mismatches: %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      #(5 * 20000);
      failCount++;
      complete_run();
   end

   initial begin
      rv = 8'($urandom(32'hf82d));
      tFuse = 4'($urandom % 11);
      wFuse = 4'($urandom % 11);
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rd(8'h00, {2'b00, tFuse, 2'b00});
      rd(8'h01, {2'b00, wFuse, 2'b00});
      rd(8'h02, 8'h00);
      rd(8'h03, 8'h00);
      // Writes lacking the change-enable bit or the unlock must not land.
      wr(8'h00, {2'b00, rv[5:0] & 6'h3e});
      cfgUnlock <= 1'b0;
      wr(8'h00, 8'h07);
      wr(8'h01, 8'h07);
      cfgUnlock <= 1'b1;
      rd(8'h00, {2'b00, tFuse, 2'b00});
      rd(8'h01, {2'b00, wFuse, 2'b00});
      wr(8'h01, 8'h01);
      rd(8'h01, 8'h00);
      rd(8'h02, 8'h00);
      wr(8'h00, 8'h03);
      rd(8'h02, 8'h01);
      check({7'h00, domainCrossingPending}, 8'h01);
      rd(8'h00, 8'h02);
      tick(3);
      rd(8'h02, 8'h00);
      check({7'h00, domainCrossingPending}, 8'h00);
      timeoutSeq(8, 3);
      wr(8'h00, 8'h2f);
      restart();
      expectResets(40, 8'h00);
      wr(8'h00, 8'h03);
      wr(8'h01, 8'h29);
      tick(3);
      timeoutSeq(8, 3);
      wr(8'h01, 8'h03);
      tick(3);
      restart();
      tick(1);
      restart();
      expectResets(1, 8'h01);
      restart();
      tick(12);
      restart();
      expectResets(2, 8'h00);
      expectResets(14, 8'h00);
      expectResets(4, 8'h01);
      wr(8'h01, 8'h2f);
      tick(3);
      // A reserved closed code skips the closed phase: no early reset.
      timeoutSeq(8, 3);
      lockFuse <= 1'b1;
      wr(8'h00, 8'h01);
      wr(8'h01, 8'h05);
      rd(8'h00, 8'h02);
      rd(8'h01, 8'h2c);
      tick(3);
      timeoutSeq(8, 3);
      // A second power-up with the enable fuses set must run at once.
      enFuse <= 1'b1;
      wenFuse <= 1'b1;
      nrst <= 1'b0;
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      repeat (2) @(posedge core_clk);
      rd(8'h00, {2'b00, tFuse, 2'b10});
      rd(8'h01, {2'b00, wFuse, 2'b10});
      restart();
      expectResets(2, 8'h01);
      repeat (4) @(posedge core_clk);
      complete_run();
   end
endmodule
`default_nettype wire
